// ===== ssc_regs.svh
// constants for the synthesizer serial configuration block
// assumes a 20 MHz system clock and a 200 kHz phase detector rate
`ifndef SSC_REGS_SVH
`define SSC_REGS_SVH

// ----------------------------------------------------------------
// serial word layout
// ----------------------------------------------------------------
`define SSC_WORD_BITS   22
`define SSC_DATA_BITS   18
`define SSC_ADDR_BITS   4
`define SSC_CNT_FULL    5'h16

// ----------------------------------------------------------------
// serial register addresses and fields
// ----------------------------------------------------------------
`define SSC_A_MAIN      4'h0
`define SSC_A_PWR       4'h2
`define SSC_A_RFH_N     4'h3
`define SSC_A_RFL_N     4'h4
`define SSC_A_IF_N      4'h5
`define SSC_F_AUX_SOURCE_SELECT_HI 13
`define SSC_F_AUX_SOURCE_SELECT_LO 12
`define SSC_F_LPWR      5
`define SSC_F_AUTOPDB   3
`define SSC_F_PDIB      1
`define SSC_F_PDRB      0
`define SSC_AUX_LDET    2'h3
`define SSC_MAIN_RST    18'h00002
`define SSC_PWR_RST     18'h00000
`define SSC_N_RST       18'h00000

// ----------------------------------------------------------------
// apb map and status bits
// ----------------------------------------------------------------
`define SSC_O_STATUS    8'h00
`define SSC_O_MASK      8'h04
`define SSC_O_CTRL      8'h08
`define SSC_O_STATE     8'h0C
`define SSC_O_MAIN      8'h10
`define SSC_O_PWR       8'h14
`define SSC_O_RFH_N     8'h18
`define SSC_O_RFL_N     8'h1C
`define SSC_O_IF_N      8'h20
`define SSC_EV_BITS     4
`define SSC_EV_RST      4'h0

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define SSC_CLK_NS      50
`define SSC_TUPDATE_NS  5000
`define SSC_TUNE_PER_X10 65
`define SSC_TUNE_CYCLES ((`SSC_TUPDATE_NS * `SSC_TUNE_PER_X10 + `SSC_CLK_NS * 10 - 1) \
	/ (`SSC_CLK_NS * 10))

`endif

// ===== ssc_pkg.sv
// types shared by the synthesizer serial configuration block
// assumes nothing beyond a SystemVerilog compiler
package ssc_pkg;
	typedef enum logic [1:0] {TS_OFF, TS_TUNE, TS_LOCK} ssc_tune_state_t;
	typedef enum logic {RF_HIGH, RF_LOW} ssc_rf_sel_t;
endpackage : ssc_pkg

// ===== ssc_serial_rx.sv
// three-wire serial receiver: shifts 22-bit words, delivers on enable rise
// assumes serial pins are asynchronous to clk and much slower than it
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_serial_rx import ssc_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        sclk,
	input  wire logic        serial_enable_n,
	input  wire logic        serial_data_in,
	output logic [21:0]      wordOut,
	output logic             commit,
	output logic             shortWord
);
	logic [2:0]  sclkQ;
	logic [2:0]  senQ;
	logic [1:0]  sdQ;
	logic [21:0] shift;
	logic [4:0]  count;
	logic        sclkRise;
	logic        senRise;

	// ------------------------------------------------------------
	// pin synchronisers; stage 0 feeds only stage 1
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sclkQ <= 3'h0;
			senQ  <= 3'h7;
			sdQ   <= 2'h0;
		end else begin
			sclkQ <= {sclkQ[1:0], sclk};
			senQ  <= {senQ[1:0], serial_enable_n};
			sdQ   <= {sdQ[0], serial_data_in};
		end
	end
	assign sclkRise = sclkQ[1] && !sclkQ[2];
	assign senRise  = senQ[1] && !senQ[2];

	// ------------------------------------------------------------
	// shift register; older bits fall off the top
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			shift <= 22'h000000;
		end else if (!senQ[1] && sclkRise) begin
			shift <= {shift[20:0], sdQ[1]}; // RQ2 RQ5
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n || senQ[1]) begin
			count <= 5'h00; // RQ4
		end else if (sclkRise && count != `SSC_CNT_FULL) begin
			count <= count + 5'h01;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wordOut   <= 22'h000000;
			commit    <= 1'b0;
			shortWord <= 1'b0;
		end else begin
			if (senRise) begin
				wordOut <= shift; // RQ3
			end
			commit    <= senRise && count == `SSC_CNT_FULL; // RQ1
			shortWord <= senRise && count != `SSC_CNT_FULL;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_shift_sample: assert property (!senQ[1] && sclkRise |=> // RQ2
		shift == {$past(shift[20:0]), $past(sdQ[1])})
		else $error("shift register missed a serial bit");
	a_idle_hold: assert property (senQ[1] |=> $stable(shift)) // RQ4
		else $error("shift register moved while disabled");
	a_word_length: assert property (commit |-> $past(count) == `SSC_CNT_FULL) // RQ1
		else $error("word delivered without 22 bits");
	a_last_bits: assert property (senRise |=> wordOut == $past(shift)) // RQ5
		else $error("delivered word is not the last 22 bits");
endmodule : ssc_serial_rx
`default_nettype wire

// ===== ssc_tune_timer.sv
// self-tuning sequencer for one loop: tune window, then loop control
// assumes powered and retune come from logic on clk
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module ssc_tune_timer import ssc_pkg::*; (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic powered,
	input  wire logic retune,
	output logic      tuning,
	output logic      pllControl,
	output logic      tuneDone
);
	localparam logic [9:0] LAST = 10'(`SSC_TUNE_CYCLES - 1);
	ssc_tune_state_t state;
	logic [9:0]      cnt;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= TS_OFF;
		end else begin
			case (state)
			TS_OFF:  if (powered) state <= TS_TUNE; // RQ6
			TS_TUNE: if (!powered) state <= TS_OFF;
				else if (cnt == LAST && !retune) state <= TS_LOCK; // RQ14
			TS_LOCK: if (!powered) state <= TS_OFF;
				else if (retune) state <= TS_TUNE; // RQ6
			default: state <= TS_OFF;
			endcase
		end
	end

	// a retune inside the window restarts it from zero
	always_ff @(posedge clk) begin
		if (!rst_n || state != TS_TUNE || retune) begin
			cnt <= 10'h000;
		end else begin
			cnt <= cnt + 10'h001;
		end
	end

	assign tuning     = state == TS_TUNE;
	assign pllControl = state == TS_LOCK; // RQ7
	assign tuneDone   = tuning && powered && !retune && cnt == LAST;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_tune_start: assert property ($rose(powered) |=> tuning) // RQ6
		else $error("powerup did not start self-tuning");
	a_tune_len: assert property (tuning |-> cnt <= LAST) // RQ14
		else $error("self-tuning window too long");
	a_loop_ctrl: assert property (tuneDone |=> pllControl && !tuning) // RQ7
		else $error("loop not given control after tuning");
endmodule : ssc_tune_timer
`default_nettype wire

// ===== ssc_synth_cfg.sv
// synthesizer configuration: serial port, power, tuning, lock detect, apb
// assumes apb on clk; serial pins and loop limit flags are asynchronous
//
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
// Functional notes
// RQ1 - word is 18 data plus 4 address bits
// RQ2 - sample data on clock rise while enabled
// RQ3 - enable rise stores data at address
// RQ4 - ignore clock and data while disabled
// RQ5 - keep only the last 22 bits
// RQ6 - tune on powerup or new frequency
// RQ7 - loop takes over after tuning
// RQ8 - lock flag high near compensation limit
// RQ9 - lock flag high while any loop tunes
// RQ10 - at most one rf loop active
// RQ11 - host retunes when lock flag rises
// RQ12 - aux output shows lock flag when selected
// RQ13 - rf divider write selects that loop
// RQ14 - tuning lasts 6.5 update periods
// RQ15 - pin powers down; port stays writable
// RQ16 - msb first, address in last bits
// RQ17 - unknown address words are dropped
module ssc_synth_cfg import ssc_pkg::*; (
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sclk,
	input  wire logic        serial_enable_n,
	input  wire logic        serial_data_in,
	input  wire logic        power_down_n_pin,
	input  wire logic        ifNearLimit,
	input  wire logic        rfNearLimit,
	output logic             lock_detect_n,
	output logic             aux_output_pin,
	output logic             irq,
	output logic             ifEnable,
	output logic             rfHighEnable,
	output logic             rfLowEnable,
	output logic             ifLowPower
);
	logic [1:0]  pwdnQ;
	logic [1:0]  ifNearQ;
	logic [1:0]  rfNearQ;
	logic [21:0] word;
	logic        commit;
	logic        shortWord;
	logic [17:0] wData;
	logic [3:0]  wAddr;
	logic        goodWrite;
	logic        badWrite;
	logic [17:0] mainCfg;
	logic [17:0] pwrCfg;
	logic [17:0] rfHighN;
	logic [17:0] rfLowN;
	logic [17:0] ifN;
	ssc_rf_sel_t activeRf;
	logic        ifOn;
	logic        rfOn;
	logic        ifPow;
	logic        rfhPow;
	logic        rflPow;
	logic        swRetune;
	logic        ifTune;
	logic        rfhTune;
	logic        rflTune;
	logic        ifCtl;
	logic        rfhCtl;
	logic        rflCtl;
	logic        ifDone;
	logic        rfhDone;
	logic        rflDone;
	logic        next_lockN;
	logic [3:0]  events;
	logic [3:0]  status;
	logic [3:0]  mask;
	logic        apbSetup;
	logic        apbWrite;
	logic [31:0] next_prdata;
	logic        next_pslverr;

	function automatic logic addrKnown(input logic [3:0] a);
		addrKnown = a == `SSC_A_MAIN || a == `SSC_A_PWR || a == `SSC_A_RFH_N
			|| a == `SSC_A_RFL_N || a == `SSC_A_IF_N;
	endfunction : addrKnown

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pwdnQ   <= 2'h0;
			ifNearQ <= 2'h0;
			rfNearQ <= 2'h0;
		end else begin
			pwdnQ   <= {pwdnQ[0], power_down_n_pin};
			ifNearQ <= {ifNearQ[0], ifNearLimit};
			rfNearQ <= {rfNearQ[0], rfNearLimit};
		end
	end

	// ------------------------------------------------------------
	// serial port and register commit
	// ------------------------------------------------------------
	ssc_serial_rx u_rx (
		.clk             (clk),
		.rst_n           (rst_n),
		.sclk            (sclk),
		.serial_enable_n (serial_enable_n),
		.serial_data_in  (serial_data_in),
		.wordOut         (word),
		.commit          (commit),
		.shortWord       (shortWord)
	);

	assign wData     = word[21:4]; // RQ16
	assign wAddr     = word[3:0]; // RQ16
	assign goodWrite = commit && addrKnown(wAddr); // RQ17
	assign badWrite  = (commit && !addrKnown(wAddr)) || shortWord;

	// the port is never gated by power state, so it stays writable
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mainCfg <= `SSC_MAIN_RST;
			pwrCfg  <= `SSC_PWR_RST;
			rfHighN <= `SSC_N_RST;
			rfLowN  <= `SSC_N_RST;
			ifN     <= `SSC_N_RST;
		end else if (goodWrite) begin // RQ15
			case (wAddr)
			`SSC_A_MAIN:  mainCfg <= wData; // RQ3
			`SSC_A_PWR:   pwrCfg  <= wData;
			`SSC_A_RFH_N: rfHighN <= wData;
			`SSC_A_RFL_N: rfLowN  <= wData;
			`SSC_A_IF_N:  ifN     <= wData;
			default:      mainCfg <= mainCfg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			activeRf <= RF_HIGH;
		end else if (goodWrite && wAddr == `SSC_A_RFH_N) begin
			activeRf <= RF_HIGH; // RQ13
		end else if (goodWrite && wAddr == `SSC_A_RFL_N) begin
			activeRf <= RF_LOW; // RQ13
		end
	end

	// ------------------------------------------------------------
	// power and self-tuning
	// ------------------------------------------------------------
	assign ifOn   = pwdnQ[1] && (mainCfg[`SSC_F_AUTOPDB] || pwrCfg[`SSC_F_PDIB]); // RQ15
	assign rfOn   = pwdnQ[1] && (mainCfg[`SSC_F_AUTOPDB] || pwrCfg[`SSC_F_PDRB]); // RQ15
	assign ifPow  = ifOn;
	assign rfhPow = rfOn && activeRf == RF_HIGH; // RQ10
	assign rflPow = rfOn && activeRf == RF_LOW; // RQ10

	ssc_tune_timer u_tune_if (
		.clk        (clk),
		.rst_n      (rst_n),
		.powered    (ifPow),
		.retune     ((goodWrite && wAddr == `SSC_A_IF_N) || swRetune),
		.tuning     (ifTune),
		.pllControl (ifCtl),
		.tuneDone   (ifDone)
	);

	ssc_tune_timer u_tune_rfh (
		.clk        (clk),
		.rst_n      (rst_n),
		.powered    (rfhPow),
		.retune     ((goodWrite && wAddr == `SSC_A_RFH_N) || swRetune),
		.tuning     (rfhTune),
		.pllControl (rfhCtl),
		.tuneDone   (rfhDone)
	);

	ssc_tune_timer u_tune_rfl (
		.clk        (clk),
		.rst_n      (rst_n),
		.powered    (rflPow),
		.retune     ((goodWrite && wAddr == `SSC_A_RFL_N) || swRetune),
		.tuning     (rflTune),
		.pllControl (rflCtl),
		.tuneDone   (rflDone)
	);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ifEnable     <= 1'b0;
			rfHighEnable <= 1'b0;
			rfLowEnable  <= 1'b0;
			ifLowPower   <= 1'b0;
		end else begin
			ifEnable     <= ifPow;
			rfHighEnable <= rfhPow;
			rfLowEnable  <= rflPow;
			ifLowPower   <= mainCfg[`SSC_F_LPWR];
		end
	end

	// ------------------------------------------------------------
	// lock detect and aux output
	// ------------------------------------------------------------
	// near-limit flags only count once the loop owns the vco
	assign next_lockN = ifTune || rfhTune || rflTune // RQ9
		|| (ifNearQ[1] && ifCtl) || (rfNearQ[1] && (rfhCtl || rflCtl)); // RQ8

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			lock_detect_n  <= 1'b0;
			aux_output_pin <= 1'b0;
		end else begin
			lock_detect_n  <= next_lockN;
			aux_output_pin <= mainCfg[`SSC_F_AUX_SOURCE_SELECT_HI:`SSC_F_AUX_SOURCE_SELECT_LO] == `SSC_AUX_LDET
				&& next_lockN; // RQ12
		end
	end

	// ------------------------------------------------------------
	// events and interrupt
	// ------------------------------------------------------------
	// a rising lock flag is the host's cue to retune
	assign events = {ifDone || rfhDone || rflDone,
		next_lockN && !lock_detect_n, badWrite, goodWrite}; // RQ11

	// set beats a same-cycle write-one-to-clear
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status <= `SSC_EV_RST;
		end else if (apbWrite && paddr == `SSC_O_STATUS) begin
			status <= (status & ~pwdata[3:0]) | events;
		end else begin
			status <= status | events;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mask <= `SSC_EV_RST;
		end else if (apbWrite && paddr == `SSC_O_MASK) begin
			mask <= pwdata[3:0];
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(status & mask);
		end
	end

	// ------------------------------------------------------------
	// apb slave, zero wait states
	// ------------------------------------------------------------
	assign apbSetup = psel && !penable;
	assign apbWrite = psel && penable && pready && pwrite;
	assign swRetune = apbWrite && paddr == `SSC_O_CTRL && pwdata[0]; // RQ11

	always_comb begin
		next_prdata  = 32'h00000000;
		next_pslverr = 1'b0;
		case (paddr)
		`SSC_O_STATUS: next_prdata = {28'h0000000, status};
		`SSC_O_MASK:   next_prdata = {28'h0000000, mask};
		`SSC_O_CTRL:   next_prdata = 32'h00000000;
		`SSC_O_STATE:  next_prdata = {24'h000000, activeRf == RF_LOW, pwdnQ[1],
			rfOn, ifOn, rflTune, rfhTune, ifTune, lock_detect_n};
		`SSC_O_MAIN:   next_prdata = {14'h0000, mainCfg};
		`SSC_O_PWR:    next_prdata = {14'h0000, pwrCfg};
		`SSC_O_RFH_N:  next_prdata = {14'h0000, rfHighN};
		`SSC_O_RFL_N:  next_prdata = {14'h0000, rfLowN};
		`SSC_O_IF_N:   next_prdata = {14'h0000, ifN};
		default:       next_pslverr = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else begin
			pready  <= apbSetup;
			pslverr <= apbSetup && next_pslverr;
			if (apbSetup && !pwrite) begin
				prdata <= next_prdata;
			end
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	sequence s_if_write;
		commit && wAddr == `SSC_A_IF_N;
	endsequence
	sequence s_if_stored(logic [17:0] d);
		ifN == d;
	endsequence

	a_commit_store: assert property (s_if_write |=> s_if_stored($past(wData))) // RQ3
		else $error("if divider word not stored");
	a_addr_split: assert property (goodWrite && wAddr == `SSC_A_RFL_N // RQ16
		|=> rfLowN == $past(word[21:4]))
		else $error("data field taken from wrong bits");
	a_bad_addr: assert property (commit && !addrKnown(wAddr) |=> // RQ17
		$stable(mainCfg) && $stable(pwrCfg) && $stable(rfHighN) && $stable(ifN))
		else $error("unknown address changed configuration");
	a_rf_select: assert property (goodWrite && wAddr == `SSC_A_RFL_N // RQ13
		|=> activeRf == RF_LOW ##1 !rfHighEnable)
		else $error("rf low divider write did not select its loop");
	a_one_rf: assert property (!(rfHighEnable && rfLowEnable)) // RQ10
		else $error("both rf loops active");
	a_power_down_n_pin_pin: assert property (!pwdnQ[1] |=> !ifEnable && !rfHighEnable && !rfLowEnable) // RQ15
		else $error("pin power-down not obeyed");
	a_ld_tune: assert property ((ifTune || rfhTune || rflTune) |=> lock_detect_n) // RQ9
		else $error("lock flag low during self-tuning");
	a_ld_near: assert property (!(ifTune || rfhTune || rflTune) && !(ifNearQ[1] && ifCtl) // RQ8
		&& !(rfNearQ[1] && (rfhCtl || rflCtl)) |=> !lock_detect_n)
		else $error("lock flag high without cause");
	a_aux_sel: assert property (mainCfg[13:12] == `SSC_AUX_LDET && $stable(mainCfg) // RQ12
		|=> aux_output_pin == lock_detect_n)
		else $error("aux output does not follow lock flag");
endmodule : ssc_synth_cfg
`default_nettype wire

// ===== ssc_serial_host.sv
// serial host model: drives the three-wire programming port of the block
// assumes clk at 20 MHz; one serial bit takes 8 clk, a 400 ns sclk period
`timescale 1ns/1ps
`default_nettype none
module ssc_serial_host (
	input  wire logic clk,
	output var  logic sclk,
	output var  logic serial_enable_n,
	output var  logic serial_data_in
);
	initial begin
		sclk            = 1'h0;
		serial_enable_n = 1'h1;
		serial_data_in  = 1'h0;
	end

	// ----------------------------------------------------------------
	// bit and word transfers
	// ----------------------------------------------------------------
	// data settles 2 clk before the rise and is held 2 clk past the fall
	task automatic bit_out(input logic b);
		serial_data_in <= b;
		repeat (2) @(posedge clk);
		sclk <= 1'h1;
		repeat (4) @(posedge clk);
		sclk <= 1'h0;
		repeat (2) @(posedge clk);
	endtask : bit_out

	// lead junk bits go first; drop trims the tail to make a short word
	task automatic send_word(input logic [21:0] w, input int lead, input int drop);
		int i;
		@(posedge clk);
		serial_enable_n <= 1'h0;
		for (i = 0; i < lead; i++) bit_out(i[0]);
		for (i = 21; i >= drop; i--) bit_out(w[i]);
		repeat (4) @(posedge clk);
		serial_enable_n <= 1'h1;
		// released line shows no stale bit
		serial_data_in  <= ~serial_data_in;
	endtask : send_word

	// clock and data wiggle with the port disabled
	task automatic noise(input int n);
		int i;
		@(posedge clk);
		for (i = 0; i < n; i++) bit_out(i[0]);
		serial_data_in <= ~serial_data_in;
	endtask : noise
endmodule : ssc_serial_host
`default_nettype wire

// ===== synth_serial_cfg_selftune_tb.sv
// testbench for the synthesizer configuration block
// assumes the serial host model and the register constants header
`timescale 1ns/1ps
`default_nettype none
`include "ssc_regs.svh"
module synth_serial_cfg_selftune_tb;
	typedef struct packed {logic [3:0] a; logic [17:0] d; logic [7:0] o;} ssc_row_t;
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rdData;
	logic        sclk, serial_enable_n, serial_data_in, power_down_n_pin;
	logic        ifNearLimit, rfNearLimit, lock_detect_n, aux_output_pin, rdErr;
	logic        ifEnable, rfHighEnable, rfLowEnable, ifLowPower;
	int          nErrors = 0;
	int          testsRun = 0;
	int          cycles = 0;
	int          i;
	ssc_row_t    rows [5] = '{
		'{`SSC_A_MAIN, 18'h03028, `SSC_O_MAIN}, '{`SSC_A_PWR, 18'h00003, `SSC_O_PWR},
		'{`SSC_A_IF_N, 18'h1FFFF, `SSC_O_IF_N}, '{`SSC_A_RFL_N, 18'h15432, `SSC_O_RFL_N},
		'{`SSC_A_RFH_N, 18'h2ABCD, `SSC_O_RFH_N}};

	ssc_synth_cfg dut (.clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .sclk, .serial_enable_n, .serial_data_in, .power_down_n_pin,
		.ifNearLimit, .rfNearLimit, .lock_detect_n, .aux_output_pin, .irq, .ifEnable,
		.rfHighEnable, .rfLowEnable, .ifLowPower);
	ssc_serial_host host (.clk, .sclk, .serial_enable_n, .serial_data_in);

	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	task automatic printVerdict;
		if (nErrors == 0 && testsRun > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : printVerdict

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		testsRun++;
		if (got !== exp) begin
			nErrors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic chk1(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask : chk1

	// holds the request until pready is seen high at a rising edge or 16 edges pass
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'h1 && k < 16);
		if (pready !== 1'h1) nErrors++;
		rdData = prdata;
		rdErr  = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
	endtask : apb

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		apb(1'h0, a, 32'h0);
		chk(rdData, exp);
	endtask : rd

	// register lands 4 clk after the enable rise
	task automatic word(input logic [21:0] w, input int lead, input int drop);
		host.send_word(w, lead, drop);
		repeat (8) @(posedge clk);
	endtask : word

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 12000) begin
			nErrors++;
			printVerdict;
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		rst_n            = 1'h0;
		psel             = 1'h0;
		penable          = 1'h0;
		pwrite           = 1'h0;
		paddr            = 8'h00;
		pwdata           = 32'h0;
		power_down_n_pin = 1'h1;
		ifNearLimit      = 1'h0;
		rfNearLimit      = 1'h0;
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		repeat (3) @(posedge clk);
		chk1(lock_detect_n, 1'h0);
		rd(`SSC_O_MAIN, {14'h0, `SSC_MAIN_RST});
		apb(1'h0, 8'h40, 32'h0);
		chk1(rdErr, 1'h1);
		chk(rdData, 32'h0);
		for (i = 0; i < 5; i++) begin
			word({rows[i].d, rows[i].a}, 0, 0);
			rd(rows[i].o, {14'h0, rows[i].d});
		end
		repeat (700) @(posedge clk);
		chk1(lock_detect_n, 1'h0);
		chk1(ifLowPower, 1'h1);
		// near-limit flag, interrupt raised, cleared, then masked
		apb(1'h1, `SSC_O_STATUS, 32'hF);
		apb(1'h1, `SSC_O_MASK, 32'h4);
		rfNearLimit <= 1'h1;
		repeat (6) @(posedge clk);
		chk1(lock_detect_n, 1'h1);
		chk1(aux_output_pin, 1'h1);
		chk1(irq, 1'h1);
		rd(`SSC_O_STATUS, 32'h4);
		apb(1'h1, `SSC_O_STATUS, 32'h4);
		repeat (3) @(posedge clk);
		chk1(irq, 1'h0);
		apb(1'h1, `SSC_O_MASK, 32'h0);
		rfNearLimit <= 1'h0;
		ifNearLimit <= 1'h1;
		repeat (6) @(posedge clk);
		chk1(lock_detect_n, 1'h1);
		chk1(irq, 1'h0);
		ifNearLimit <= 1'h0;
		repeat (4) @(posedge clk);
		chk1(lock_detect_n, 1'h0);
		// host re-tunes by reprogramming the low band divider
		word({18'h15432, `SSC_A_RFL_N}, 0, 0);
		chk1(lock_detect_n, 1'h1);
		chk1(rfLowEnable, 1'h1);
		chk1(rfHighEnable, 1'h0);
		repeat (630) @(posedge clk);
		chk1(lock_detect_n, 1'h1);
		repeat (30) @(posedge clk);
		chk1(lock_detect_n, 1'h0);
		chk1(aux_output_pin, 1'h0);
		// disabled-port noise cannot complete a short word
		apb(1'h1, `SSC_O_STATUS, 32'hF);
		host.noise(5);
		word({18'h00000, `SSC_A_MAIN}, 0, 1);
		rd(`SSC_O_MAIN, 32'h03028);
		rd(`SSC_O_STATUS, 32'h2);
		apb(1'h1, `SSC_O_STATUS, 32'hF);
		word({18'h00000, 4'hF}, 0, 0);
		rd(`SSC_O_STATUS, 32'h2);
		rd(`SSC_O_MAIN, 32'h03028);
		word({18'h03008, `SSC_A_MAIN}, 6, 0);
		rd(`SSC_O_MAIN, 32'h03008);
		chk1(ifLowPower, 1'h0);
		// pin power-down overrides registers; port stays writable
		power_down_n_pin <= 1'h0;
		repeat (6) @(posedge clk);
		chk1(ifEnable, 1'h0);
		chk1(rfLowEnable, 1'h0);
		word({18'h00001, `SSC_A_PWR}, 0, 0);
		rd(`SSC_O_PWR, 32'h1);
		power_down_n_pin <= 1'h1;
		repeat (8) @(posedge clk);
		chk1(ifEnable, 1'h1);
		chk1(lock_detect_n, 1'h1);
		// tune-done event, then a software retune of every powered loop
		repeat (700) @(posedge clk);
		chk1(lock_detect_n, 1'h0);
		rd(`SSC_O_STATUS, 32'hF);
		apb(1'h1, `SSC_O_STATUS, 32'hF);
		apb(1'h1, `SSC_O_CTRL, 32'h1);
		repeat (3) @(posedge clk);
		chk1(lock_detect_n, 1'h1);
		rd(`SSC_O_STATE, 32'hFB);
		printVerdict;
	end
endmodule : synth_serial_cfg_selftune_tb
`default_nettype wire
